// ===== hw/ias_consts.vh
// constants for the interrupt acceptance sequencer: register offsets,
// field positions, reset values and sequence timing.
// assumes it is included by its bare name from the design file.
`ifndef IAS_CONSTS_VH
`define IAS_CONSTS_VH

// apb byte offsets
`define IAS_OFF_IRQ_EN_UPPER   8'h00
`define IAS_OFF_IRQ_EN_MIDDLE  8'h04
`define IAS_OFF_IRQ_EN_LOWER   8'h08
`define IAS_OFF_REQ_UPPER      8'h0C
`define IAS_OFF_REQ_MIDDLE     8'h10
`define IAS_OFF_REQ_LOWER      8'h14
`define IAS_OFF_SRC_UPPER      8'h18
`define IAS_OFF_SRC_LOWER      8'h1C
`define IAS_OFF_PSW            8'h20
`define IAS_OFF_STATUS         8'h24
`define IAS_OFF_EDGE_SEL       8'hFC

// source count and its split into external and peripheral inputs
`define IAS_NUM_SRC            14
`define IAS_NUM_EXT            4
`define IAS_NUM_PERIPH         10

// processor status word fields
`define IAS_PSW_IE_BIT         2
`define IAS_PSW_BRK_BIT        4
`define IAS_PSW_RESET          8'h00

// edge select codes, two bits per external input
`define IAS_EDGE_OFF           2'h0
`define IAS_EDGE_FALL          2'h1
`define IAS_EDGE_RISE          2'h2
`define IAS_EDGE_BOTH          2'h3
`define IAS_EDGE_SEL_RESET     8'h00

// acceptance sequence, counted in oscillator periods
`define IAS_ACC_CYCLES         8
`define IAS_STEP_PUSH_PCH      3'h1
`define IAS_STEP_PUSH_PCL      3'h2
`define IAS_STEP_PUSH_PSW      3'h3
`define IAS_STEP_LOAD          3'h7

// vector table
`define IAS_VEC_EXT_A          16'hFFFA
`define IAS_VEC_EXT_B          16'hFFF8
`define IAS_VEC_EXT_C          16'hFFF6
`define IAS_VEC_EXT_D          16'hFFF4
`define IAS_VEC_UART           16'hFFF2
`define IAS_VEC_TMR0           16'hFFEE
`define IAS_VEC_TMR1           16'hFFEC
`define IAS_VEC_TMR2           16'hFFEA
`define IAS_VEC_TMR3           16'hFFE8
`define IAS_VEC_ADC            16'hFFE4
`define IAS_VEC_BIT            16'hFFE2
`define IAS_VEC_WDT            16'hFFE0

`endif

// ===== hw/ias_top.v
// interrupt acceptance and sequencing for an 8-bit cpu core, with an
// apb register port. assumes the core pulses instr_done at each
// instruction boundary and performs the memory pushes and vector fetch.
//
// Contract
// R1 - a pending request stays latched until accepted, reset or cleared.
// R2 - acceptance takes 8 clock periods after the instruction completes.
// R3 - return-from-interrupt restores the saved status word and ends service.
// R4 - first acceptance step clears the master enable flag.
// R5 - accepting a non-maskable trap blocks every further acceptance meanwhile.
// R6 - acceptance clears the accepted source's request flag.
// R7 - return pc and status word are pushed, stack pointer decremented three times.
// R8 - vector address is produced and loaded into the pc, then executed.
// R9 - master enable at zero blocks every maskable request, whatever its priority.
// R10 - enabling the master flag in a handler allows nesting of enabled sources.
// R11 - only pc and status word are saved; other registers are software's.
// R12 - the software trap has the lowest priority of all sources.
// R13 - the trap shares table call zero's vector and sets the break bit.
// R14 - simultaneous requests of different priority: the higher one is served.
// R15 - a hardware poll picks the served request among simultaneous ones.
// R16 - four external inputs are edge triggered, edge chosen by register 0xFC.
// R17 - each external input supports rising, falling or both edges.
// R18 - edges latch into request flags; priority samples them next cycle.
// R19 - an enabled active request makes the next instruction a hardware call.
// R20 - external request latency stays within twelve machine cycles.
// R21 - master enable is status bit 2, gating all maskable sources.
// R22 - source flag bits set on request and enable, never hardware cleared.
// R23 - a source with its enable bit zero is never accepted.
// R24 - software reads and writes the request flags.
// R25 - edge select gives each external input a two-bit mode field.
// R26 - acceptance starts at a boundary with the winner captured there.
`timescale 1ns/10ps
`include "ias_consts.vh"

module ias_top #(
  parameter NSRC      = `IAS_NUM_SRC,
  parameter NEXT      = `IAS_NUM_EXT,
  parameter TRAP_VEC  = 16'hFFC0
) (
  input  wire        clock,
  input  wire        reset,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata_ff,
  output reg         pready_ff,
  output reg         pslverr_ff,
  // interrupt sources
  input  wire [3:0]  ext_irq_in,
  input  wire [9:0]  periph_irq,
  // core sequencer
  input  wire        instr_done,
  input  wire        software_trap_instr,
  input  wire        set_master_enable_instr,
  input  wire        clear_master_enable_instr,
  input  wire        return_from_irq_instr,
  input  wire [7:0]  pop_psw,
  input  wire        core_psw_we,
  input  wire [7:0]  core_psw_wdata,
  input  wire [15:0] return_pc,
  output reg         hw_call_ff,
  output reg         push_strobe_ff,
  output reg  [7:0]  push_data_ff,
  output reg         sp_dec_ff,
  output reg  [15:0] vector_addr_ff,
  output reg         vector_load_ff,
  output reg  [7:0]  processor_status_word_ff
);

  // ----------------------------------------------------------------
  // state and helpers
  // ----------------------------------------------------------------
  // idle waits for a boundary; acc walks the fixed eight-cycle call
  localparam ST_IDLE = 2'b01;
  localparam ST_ACC  = 2'b10;

  reg  [1:0]      state_ff;
  reg  [1:0]      nxt_state;
  reg  [2:0]      step_ff;
  reg  [NSRC-1:0] req_ff;
  reg  [NSRC-1:0] irq_en_ff;
  reg  [NSRC-1:0] src_flag_ff;
  reg  [7:0]      ext_edge_select_ff;
  reg  [NEXT-1:0] ext_prev_ff;
  reg             trap_pend_ff;
  reg  [3:0]      win_idx_ff;
  reg             win_trap_ff;
  reg  [3:0]      depth_ff;

  // first set bit in index order is the poll winner [R14] [R15]
  function [4:0] poll;
    input [NSRC-1:0] v;
    integer i;
    begin
      poll = 5'h0;
      for (i = NSRC - 1; i >= 0; i = i - 1) begin
        if (v[i]) begin
          poll = {1'b1, i[3:0]};
        end
      end
    end
  endfunction

  // shared vectors (uart rx/tx, watchdog/watch timer) leave it to the
  // source flags to tell the handler which one fired
  function [15:0] vec_of;
    input [3:0] idx;
    begin
      case (idx)
        4'h0:        vec_of = `IAS_VEC_EXT_A;
        4'h1:        vec_of = `IAS_VEC_EXT_B;
        4'h2:        vec_of = `IAS_VEC_EXT_C;
        4'h3:        vec_of = `IAS_VEC_EXT_D;
        4'h4, 4'h5:  vec_of = `IAS_VEC_UART;
        4'h6:        vec_of = `IAS_VEC_TMR0;
        4'h7:        vec_of = `IAS_VEC_TMR1;
        4'h8:        vec_of = `IAS_VEC_TMR2;
        4'h9:        vec_of = `IAS_VEC_TMR3;
        4'hA:        vec_of = `IAS_VEC_ADC;
        4'hB:        vec_of = `IAS_VEC_BIT;
        default:     vec_of = `IAS_VEC_WDT;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // external edge detection
  // ----------------------------------------------------------------
  // prev resets low to match the assumed idle level of the pins; a pin that
  // idles high shows no false rising edge, as edge select resets to off until prev has sampled it
  wire [NEXT-1:0] ext_edge;
  genvar g;
  generate
    for (g = 0; g < NEXT; g = g + 1) begin : g_edge
      wire [1:0] mode = ext_edge_select_ff[2*g+1:2*g];  // [R25]
      wire rise = ext_irq_in[g] & ~ext_prev_ff[g];
      wire fall = ~ext_irq_in[g] & ext_prev_ff[g];
      // [R16] [R17]
      assign ext_edge[g] = (mode == `IAS_EDGE_RISE) ? rise :
                           (mode == `IAS_EDGE_FALL) ? fall :
                           (mode == `IAS_EDGE_BOTH) ? (rise | fall) : 1'b0;
    end
  endgenerate

  // ----------------------------------------------------------------
  // request polling
  // ----------------------------------------------------------------
  wire [NSRC-1:0] set_vec = {periph_irq, ext_edge};
  wire            ie      = processor_status_word_ff[`IAS_PSW_IE_BIT];
  // only registered flags are polled, so an edge waits one cycle [R18]
  wire [NSRC-1:0] pend    = req_ff & irq_en_ff;                 // [R23]
  wire [4:0]      win     = poll(pend);
  wire            mask_go = win[4] & ie;                        // [R9] [R10] [R21]
  // trap ignores the master enable and loses to a maskable winner only while that enable is set [R12]
  wire            trap_go = trap_pend_ff & ~mask_go;
  wire            start   = (state_ff == ST_IDLE) & instr_done
                            & (mask_go | trap_go);              // [R19] [R20] [R26]
  wire            acc_clr = (state_ff == ST_ACC) & (step_ff == 3'h0) & ~win_trap_ff;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // writes act only in the access cycle, once ready is already high;
  // reads are captured at setup so the data stand through the access cycle
  wire apb_wr = psel & penable & pready_ff & pwrite;
  wire [7:0] wb = pwdata[7:0];

  reg        hit;
  reg [7:0]  rd;
  always @* begin
    hit = 1'b1;
    rd  = 8'h00;
    case (paddr)
      `IAS_OFF_IRQ_EN_UPPER:  rd = {3'h0, irq_en_ff[4:0]};
      `IAS_OFF_IRQ_EN_MIDDLE: rd = {3'h0, irq_en_ff[9:5]};
      `IAS_OFF_IRQ_EN_LOWER:  rd = {4'h0, irq_en_ff[13:10]};
      `IAS_OFF_REQ_UPPER:     rd = {3'h0, req_ff[4:0]};
      `IAS_OFF_REQ_MIDDLE:    rd = {3'h0, req_ff[9:5]};
      `IAS_OFF_REQ_LOWER:     rd = {4'h0, req_ff[13:10]};
      `IAS_OFF_SRC_UPPER:     rd = {1'b0, src_flag_ff[6:0]};
      `IAS_OFF_SRC_LOWER:     rd = {1'b0, src_flag_ff[13:7]};
      `IAS_OFF_PSW:           rd = processor_status_word_ff;
      `IAS_OFF_STATUS:        rd = {state_ff[1], trap_pend_ff, 2'h0, depth_ff};
      `IAS_OFF_EDGE_SEL:      rd = ext_edge_select_ff;
      default:                hit = 1'b0;
    endcase
  end

  // software image of the request and source flags, before hardware set and clear
  reg [NSRC-1:0] req_sw;
  reg [NSRC-1:0] src_sw;
  always @* begin
    req_sw = req_ff;
    src_sw = src_flag_ff;
    if (apb_wr) begin
      case (paddr)
        `IAS_OFF_REQ_UPPER:  req_sw[4:0]   = wb[4:0];           // [R24]
        `IAS_OFF_REQ_MIDDLE: req_sw[9:5]   = wb[4:0];
        `IAS_OFF_REQ_LOWER:  req_sw[13:10] = wb[3:0];
        `IAS_OFF_SRC_UPPER:  src_sw[6:0]   = src_flag_ff[6:0] & ~wb[6:0];
        `IAS_OFF_SRC_LOWER:  src_sw[13:7]  = src_flag_ff[13:7] & ~wb[6:0];
        default:             req_sw = req_ff;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // request, enable and source flags
  // ----------------------------------------------------------------
  // accept-clear uses the frozen winner, not the live poll, so a newer
  // request arriving mid-sequence cannot have its flag cleared instead
  reg [NSRC-1:0] acc_mask;
  always @* begin
    acc_mask = {NSRC{1'b0}};
    if (acc_clr) begin
      acc_mask[win_idx_ff] = 1'b1;
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      req_ff             <= {NSRC{1'b0}};
      src_flag_ff        <= {NSRC{1'b0}};
      irq_en_ff          <= {NSRC{1'b0}};
      ext_edge_select_ff <= `IAS_EDGE_SEL_RESET;
      ext_prev_ff        <= {NEXT{1'b0}};
      trap_pend_ff       <= 1'b0;
    end else begin
      ext_prev_ff <= ext_irq_in;
      // flag held until accepted or cleared; a new event beats the clear [R1] [R6]
      req_ff      <= (req_sw & ~acc_mask) | set_vec;
      src_flag_ff <= src_sw | (req_ff & irq_en_ff);             // [R22]
      if (software_trap_instr) begin
        trap_pend_ff <= 1'b1;
      end else if (start & trap_go) begin
        trap_pend_ff <= 1'b0;
      end
      if (apb_wr) begin
        case (paddr)
          `IAS_OFF_IRQ_EN_UPPER:  irq_en_ff[4:0]     <= wb[4:0];
          `IAS_OFF_IRQ_EN_MIDDLE: irq_en_ff[9:5]     <= wb[4:0];
          `IAS_OFF_IRQ_EN_LOWER:  irq_en_ff[13:10]   <= wb[3:0];
          `IAS_OFF_EDGE_SEL:      ext_edge_select_ff <= wb;      // [R16]
          default:                irq_en_ff          <= irq_en_ff;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // acceptance sequence
  // ----------------------------------------------------------------
  // step_ff is zero in the first acc cycle; pushes fall on steps one to
  // three and the vector load on step seven, eight cycles in all
  always @* begin
    case (state_ff)
      ST_IDLE: nxt_state = start ? ST_ACC : ST_IDLE;
      // no new acceptance while here, trap or not [R5]
      ST_ACC:  nxt_state = (step_ff == `IAS_STEP_LOAD) ? ST_IDLE : ST_ACC;  // [R2]
      default: nxt_state = ST_IDLE;
    endcase
  end

  // later assignments win; the accept clear comes last so that a return at
  // the same boundary cannot reopen the mask during the call
  reg [7:0] nxt_psw;
  always @* begin
    nxt_psw = processor_status_word_ff;
    if (core_psw_we) begin
      nxt_psw = core_psw_wdata;
    end
    if (apb_wr && paddr == `IAS_OFF_PSW) begin
      nxt_psw = wb;
    end
    if (set_master_enable_instr) begin
      nxt_psw[`IAS_PSW_IE_BIT] = 1'b1;                          // [R10]
    end
    if (clear_master_enable_instr) begin
      nxt_psw[`IAS_PSW_IE_BIT] = 1'b0;
    end
    if (return_from_irq_instr) begin
      nxt_psw = pop_psw;                                        // [R3]
    end
    if (start) begin
      nxt_psw[`IAS_PSW_IE_BIT] = 1'b0;                          // [R4]
      if (trap_go) begin
        nxt_psw[`IAS_PSW_BRK_BIT] = 1'b1;                       // [R13]
      end
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      state_ff                 <= ST_IDLE;
      step_ff                  <= 3'h0;
      win_idx_ff               <= 4'h0;
      win_trap_ff              <= 1'b0;
      depth_ff                 <= 4'h0;
      processor_status_word_ff <= `IAS_PSW_RESET;
      hw_call_ff               <= 1'b0;
      push_strobe_ff           <= 1'b0;
      push_data_ff             <= 8'h00;
      sp_dec_ff                <= 1'b0;
      vector_addr_ff           <= 16'h0000;
      vector_load_ff           <= 1'b0;
    end else begin
      state_ff                 <= nxt_state;
      processor_status_word_ff <= nxt_psw;
      push_strobe_ff           <= 1'b0;
      sp_dec_ff                <= 1'b0;
      vector_load_ff           <= 1'b0;
      step_ff <= (state_ff == ST_ACC) ? step_ff + 3'h1 : 3'h0;
      if (start) begin
        // winner frozen here so the vector cannot move mid-sequence [R26]
        win_idx_ff     <= win[3:0];
        win_trap_ff    <= trap_go;
        vector_addr_ff <= trap_go ? TRAP_VEC : vec_of(win[3:0]);  // [R8] [R13]
        hw_call_ff     <= 1'b1;                                   // [R19]
      end
      if (state_ff == ST_ACC) begin
        // only pc and status word go to the stack [R7] [R11]
        case (step_ff)
          `IAS_STEP_PUSH_PCH: begin
            push_strobe_ff <= 1'b1;
            push_data_ff   <= return_pc[15:8];
            sp_dec_ff      <= 1'b1;
          end
          `IAS_STEP_PUSH_PCL: begin
            push_strobe_ff <= 1'b1;
            push_data_ff   <= return_pc[7:0];
            sp_dec_ff      <= 1'b1;
          end
          `IAS_STEP_PUSH_PSW: begin
            push_strobe_ff <= 1'b1;
            push_data_ff   <= processor_status_word_ff;
            sp_dec_ff      <= 1'b1;
          end
          `IAS_STEP_LOAD: begin
            vector_load_ff <= 1'b1;                             // [R8]
            hw_call_ff     <= 1'b0;
            depth_ff       <= depth_ff + 4'h1;
          end
          default: push_data_ff <= push_data_ff;
        endcase
      end else if (return_from_irq_instr && depth_ff != 4'h0) begin
        depth_ff <= depth_ff - 4'h1;                            // [R3]
      end
    end
  end

  // ----------------------------------------------------------------
  // apb answer: one access cycle, registered data
  // ----------------------------------------------------------------
  // zero wait states; pslverr rides with ready so an unmapped access still ends
  always @(posedge clock) begin
    if (reset) begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= psel & ~penable;
      pslverr_ff <= psel & ~penable & ~hit;
      if (psel & ~penable) begin
        prdata_ff <= {24'h000000, rd};
      end
    end
  end

endmodule

// ===== tb/ias_core_model.sv
// behavioural core sequencer: instruction boundaries and return pc.
// assumes boundaries stop while the hardware call runs.
`timescale 1ns/10ps
module ias_core_model (
  input  wire        clock,
  input  wire        reset,
  input  wire        slow,
  input  wire        hw_call_ff,
  output reg         instr_done,
  output reg  [15:0] return_pc
);
  integer cnt;
  always @(posedge clock) begin
    if (reset) begin
      instr_done <= 1'b0;
      cnt        <= 0;
      return_pc  <= 16'h1234;
    end else begin
      instr_done <= 1'b0;
      if (hw_call_ff) begin
        cnt <= 0;
      end else if (cnt >= (slow ? 5 : 1)) begin
        // pc moves only at a boundary, so pushes see a steady value
        instr_done <= 1'b1;
        cnt        <= 0;
        return_pc  <= return_pc + 16'h0003;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule

// ===== tb/ias_top_props.sv
// checker for the interrupt acceptance sequencer, bound to ias_top.
// assumes the core holds return_pc steady during a hardware call.
`timescale 1ns/10ps
module ias_props #(
  parameter TRAP_VEC = 16'hFFC0
) (
  input wire        clock,
  input wire        reset,
  input wire        psel,
  input wire        penable,
  input wire        pready_ff,
  input wire        instr_done,
  input wire        return_from_irq_instr,
  input wire [7:0]  pop_psw,
  input wire [15:0] return_pc,
  input wire        hw_call_ff,
  input wire        push_strobe_ff,
  input wire [7:0]  push_data_ff,
  input wire        sp_dec_ff,
  input wire [15:0] vector_addr_ff,
  input wire        vector_load_ff,
  input wire [7:0]  processor_status_word_ff
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // acceptance sequence, status restore on return and apb ready
  // ----------------------------------------
  sequence s_start; $rose(hw_call_ff); endsequence
  sequence s_push3; (push_strobe_ff && sp_dec_ff) [*3]; endsequence
  property p_ie; s_start |-> !processor_status_word_ff[2]; endproperty
  property p_edge; s_start |-> $past(instr_done); endproperty
  property p_len; s_start |-> hw_call_ff [*8] ##1 !hw_call_ff; endproperty
  property p_load; s_start |-> ##8 vector_load_ff; endproperty
  property p_push; s_start |-> ##1 !push_strobe_ff ##1 s_push3 ##1 !push_strobe_ff; endproperty
  property p_pc;
    s_start |-> ##2 push_data_ff == return_pc[15:8] ##1 push_data_ff == return_pc[7:0];
  endproperty
  property p_hold; hw_call_ff && $past(hw_call_ff) |-> $stable(vector_addr_ff); endproperty
  property p_mask;
    (s_start and (vector_addr_ff != TRAP_VEC)) |-> $past(processor_status_word_ff[2]);
  endproperty
  property p_brk;
    (s_start and (vector_addr_ff == TRAP_VEC)) |-> processor_status_word_ff[4];
  endproperty
  // a call taken at the same boundary clears the enable after the restore
  property p_return_from_irq_instr;
    return_from_irq_instr |=> $rose(hw_call_ff) || processor_status_word_ff == $past(pop_psw);
  endproperty
  property p_apb; psel && !penable |=> pready_ff; endproperty
  a_ie: assert property (p_ie) else $error("enable flag kept at call");
  a_edge: assert property (p_edge) else $error("call off boundary");
  a_len: assert property (p_len) else $error("call length wrong");
  a_load: assert property (p_load) else $error("vector load late");
  a_push: assert property (p_push) else $error("push count wrong");
  a_pc: assert property (p_pc) else $error("pushed pc wrong");
  a_hold: assert property (p_hold) else $error("vector moved");
  a_mask: assert property (p_mask) else $error("masked call taken");
  a_brk: assert property (p_brk) else $error("break bit missing");
  a_return_from_irq_instr: assert property (p_return_from_irq_instr) else $error("status not restored");
  a_apb: assert property (p_apb) else $error("no ready");
endmodule
bind ias_top ias_props #(.TRAP_VEC(TRAP_VEC)) i_ias_props (
  .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pready_ff(pready_ff),
  .instr_done(instr_done), .return_from_irq_instr(return_from_irq_instr),
  .pop_psw(pop_psw), .return_pc(return_pc), .hw_call_ff(hw_call_ff),
  .push_strobe_ff(push_strobe_ff), .push_data_ff(push_data_ff), .sp_dec_ff(sp_dec_ff),
  .vector_addr_ff(vector_addr_ff), .vector_load_ff(vector_load_ff),
  .processor_status_word_ff(processor_status_word_ff));

// ===== tb/test_interrupt_accept_sequencer.sv
// self-checking bench for ias_top with a core model and apb master.
// assumes ias_consts.vh is on the include path.
`timescale 1ns/10ps
`include "ias_consts.vh"
module test_interrupt_accept_sequencer;
  localparam TV = 16'hFFC0;
  reg clock, reset, psel, penable, pwrite, slow, err;
  reg [7:0] paddr, pop_psw, core_psw_wdata;
  reg [31:0] pwdata, rd;
  reg [3:0] ext_irq_in;
  reg [9:0] periph_irq;
  reg software_trap_instr, set_master_enable_instr, clear_master_enable_instr;
  reg return_from_irq_instr, core_psw_we;
  wire [31:0] prdata_ff;
  wire pready_ff, pslverr_ff, instr_done, hw_call_ff, push_strobe_ff, sp_dec_ff, vector_load_ff;
  wire [7:0] push_data_ff, processor_status_word_ff;
  wire [15:0] return_pc, vector_addr_ff;
  integer miscompares, tests_run, seed, n, i, j, a, b;

  ias_top #(.TRAP_VEC(TV)) i_ias_top (.clock(clock), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
    .ext_irq_in(ext_irq_in), .periph_irq(periph_irq), .instr_done(instr_done),
    .software_trap_instr(software_trap_instr),
    .set_master_enable_instr(set_master_enable_instr),
    .clear_master_enable_instr(clear_master_enable_instr),
    .return_from_irq_instr(return_from_irq_instr), .pop_psw(pop_psw),
    .core_psw_we(core_psw_we), .core_psw_wdata(core_psw_wdata), .return_pc(return_pc),
    .hw_call_ff(hw_call_ff), .push_strobe_ff(push_strobe_ff), .push_data_ff(push_data_ff),
    .sp_dec_ff(sp_dec_ff), .vector_addr_ff(vector_addr_ff),
    .vector_load_ff(vector_load_ff), .processor_status_word_ff(processor_status_word_ff));
  ias_core_model i_ias_core_model (.clock(clock), .reset(reset), .slow(slow),
    .hw_call_ff(hw_call_ff), .instr_done(instr_done), .return_pc(return_pc));

  always #2.5 clock = ~clock;

  task final_report;
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input [31:0] seen, input [31:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task apb(input w, input [7:0] ad, input [31:0] d);
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= ad; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // only the watchdog ends a wait for ready
    do begin @(posedge clock); end while (pready_ff !== 1'b1);
    rd = prdata_ff;
    err = pslverr_ff;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  function [15:0] vec(input integer s);
    case (s)
      0: vec = `IAS_VEC_EXT_A;   1: vec = `IAS_VEC_EXT_B;   2: vec = `IAS_VEC_EXT_C;
      3: vec = `IAS_VEC_EXT_D;   4, 5: vec = `IAS_VEC_UART; 6: vec = `IAS_VEC_TMR0;
      7: vec = `IAS_VEC_TMR1;    8: vec = `IAS_VEC_TMR2;    9: vec = `IAS_VEC_TMR3;
      10: vec = `IAS_VEC_ADC;    11: vec = `IAS_VEC_BIT;    default: vec = `IAS_VEC_WDT;
    endcase
  endfunction

  // wait for the vector load, check it, then return with master enable set
  task served(input [15:0] ev);
    n = 0;
    while (vector_load_ff !== 1'b1 && n < 60) begin @(posedge clock); n = n + 1; end
    chk(vector_load_ff, 1'b1);
    chk(vector_addr_ff, ev);
    @(posedge clock); pop_psw <= 8'h04; return_from_irq_instr <= 1'b1;
    @(posedge clock); return_from_irq_instr <= 1'b0;
  endtask

  task quiet;
    n = 0;
    repeat (30) begin @(posedge clock); if (hw_call_ff === 1'b1) n = n + 1; end
    chk(n, 0);
  endtask

  task pp(input [9:0] bits);
    @(posedge clock); periph_irq <= bits;
    @(posedge clock); periph_irq <= 10'h000;
  endtask

  initial begin
    #(5 * 20000);
    miscompares = miscompares + 1;
    final_report;
  end

  initial begin
    clock = 0; reset = 1; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00; pwdata = 0;
    ext_irq_in = 4'h0; periph_irq = 10'h000; software_trap_instr = 0; slow = 0;
    set_master_enable_instr = 0; clear_master_enable_instr = 0; return_from_irq_instr = 0;
    pop_psw = 8'h00; core_psw_we = 0; core_psw_wdata = 8'h00;
    miscompares = 0; tests_run = 0; seed = 32'h5e82;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    apb(0, `IAS_OFF_EDGE_SEL, 0); chk(rd, 0);
    apb(0, `IAS_OFF_PSW, 0); chk(rd, 0);
    apb(0, 8'h40, 0); chk(err, 1);
    $display("reset values done");
    for (i = 0; i < 4; i = i + 1) for (j = 0; j < 4; j = j + 1) begin
      apb(1, `IAS_OFF_EDGE_SEL, j << (2 * i));
      @(posedge clock) ext_irq_in[i] <= 1'b1;
      repeat (3) @(posedge clock);
      apb(0, `IAS_OFF_REQ_UPPER, 0); chk(rd[i], j[1]);
      apb(1, `IAS_OFF_REQ_UPPER, 0);
      @(posedge clock) ext_irq_in[i] <= 1'b0;
      repeat (3) @(posedge clock);
      apb(0, `IAS_OFF_REQ_UPPER, 0); chk(rd[i], j[0]);
      apb(1, `IAS_OFF_REQ_UPPER, 0);
    end
    $display("edge modes done");
    apb(1, `IAS_OFF_IRQ_EN_UPPER, 32'hFF);
    apb(1, `IAS_OFF_IRQ_EN_MIDDLE, 32'hFF);
    apb(1, `IAS_OFF_IRQ_EN_LOWER, 32'hFF);
    pp(10'h020); quiet;
    apb(0, `IAS_OFF_REQ_MIDDLE, 0); chk(rd[4], 1);
    @(posedge clock) set_master_enable_instr <= 1'b1;
    @(posedge clock) set_master_enable_instr <= 1'b0;
    served(vec(9));
    apb(0, `IAS_OFF_REQ_MIDDLE, 0); chk(rd[4], 0);
    apb(0, `IAS_OFF_SRC_LOWER, 0); chk(rd[2], 1);
    apb(1, `IAS_OFF_IRQ_EN_MIDDLE, 0);
    pp(10'h020); quiet;
    apb(1, `IAS_OFF_REQ_MIDDLE, 0);
    apb(1, `IAS_OFF_IRQ_EN_MIDDLE, 32'hFF);
    $display("masking done");
    apb(1, `IAS_OFF_EDGE_SEL, 32'h80);
    @(posedge clock) ext_irq_in[3] <= 1'b1;
    served(vec(3));
    chk(n < 20, 1);
    ext_irq_in[3] <= 1'b0;
    @(posedge clock);
    software_trap_instr <= 1'b1; periph_irq <= 10'h001;
    @(posedge clock);
    software_trap_instr <= 1'b0; periph_irq <= 10'h000;
    served(vec(4));
    served(TV);
    $display("trap done");
    @(posedge clock) clear_master_enable_instr <= 1'b1;
    @(posedge clock) clear_master_enable_instr <= 1'b0;
    apb(0, `IAS_OFF_PSW, 0); chk(rd[`IAS_PSW_IE_BIT], 0);
    @(posedge clock) core_psw_we <= 1'b1;
    core_psw_wdata <= 8'h04;
    @(posedge clock) core_psw_we <= 1'b0;
    apb(0, `IAS_OFF_PSW, 0); chk(rd, 32'h1 << `IAS_PSW_IE_BIT);
    $display("status word writes done");
    for (i = 0; i < 6; i = i + 1) begin
      a = $unsigned($random(seed)) % 10;
      b = (a + 1 + $unsigned($random(seed)) % 9) % 10;
      pp((10'h001 << a) | (10'h001 << b));
      served(vec(4 + (a < b ? a : b)));
      served(vec(4 + (a < b ? b : a)));
      slow <= $random(seed);
    end
    $display("random pairs done");
    final_report;
  end
endmodule
